/* File: mud_uart.sv */
// Modem-side (DCE) asynchronous serial port with AHB-Lite registers.
// Assumes one AHB-Lite master, 25 MHz sys_clk_i, pins from another domain.
//
// Behaviour
// - Eight lines: RXD,CTS,DSR,DCD,RI driven; TXD,RTS,DTR received.
// - Low means zero bit or ON; high means one bit or OFF.
// - Device is DCE: host data arrives on TXD, device data leaves on RXD.
// - Flow control selectable: RTS/CTS hardware, XON/XOFF software, or none.
// - Hardware RTS/CTS flow control is active after reset.
// - Autobaud measures once at start-up; rate kept until reconfigured.
// - Baud setting zero selects one-shot autobaud and is the reset default.
// - Fixed rates 9600 through 921600 b/s selectable by configuration.
// - Without autobaud or other choice the rate is 115200 b/s.
// - Seven or eight data bits; no parity 1/2 stops, or parity 1 stop.
// - Default frame 8N1: format code three, parity code one.
// - DSR ON in data mode, OFF in command mode by default.
// - DTR ON-to-OFF enters online command mode and requests OK code.
// - DCD ON while carrier detected, OFF otherwise, by default.
// - Multiplexing off by default; channel 0 control, 1 to 5 traffic.
// - Pins tri-stated at power-up, then set to reset state.
// - RXD held high whenever no frame is being sent.
// - Internal pull-up on TXD input keeps it high when undriven.
// - CTS ON at init; three more characters accepted after CTS OFF.
// - Transmission stops within two characters after RTS OFF.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "mud_defines.svh"
module mud_uart (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire mud_pkg::mud_pin_in_t pin_i,
	output mud_pkg::mud_pin_out_t pin_o,
	output logic pin_oe_o,
	output logic pullup_en_o
);
	// ==========================================================
	// Functions
	function automatic logic [15:0] rate_div(input logic [3:0] sel);
		case (sel)
			4'h1: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_9600);
			4'h2: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_19200);
			4'h3: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_38400);
			4'h4: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_57600);
			4'h6: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_230400);
			4'h7: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_460800);
			4'h8: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_921600);
			default: rate_div = 16'(`MUD_SYS_CLK_HZ / `MUD_RATE_115200);
		endcase
	endfunction : rate_div

	function automatic mud_pkg::mud_fmt_t fmt_dec(input logic [2:0] code);
		case (code)
			`MUD_FMT_8N2: fmt_dec = '{db8: 1'b1, pe: 1'b0, stop2: 1'b1};
			`MUD_FMT_8P1: fmt_dec = '{db8: 1'b1, pe: 1'b1, stop2: 1'b0};
			`MUD_FMT_7N2: fmt_dec = '{db8: 1'b0, pe: 1'b0, stop2: 1'b1};
			`MUD_FMT_7P1: fmt_dec = '{db8: 1'b0, pe: 1'b1, stop2: 1'b0};
			`MUD_FMT_7N1: fmt_dec = '{db8: 1'b0, pe: 1'b0, stop2: 1'b0};
			default: fmt_dec = '{db8: 1'b1, pe: 1'b0, stop2: 1'b0};
		endcase
	endfunction : fmt_dec

	function automatic logic par_of(input logic [7:0] d, input logic db8,
		input logic even);
		logic x;
		x = db8 ? ^d : ^d[6:0];
		par_of = even ? x : ~x;
	endfunction : par_of

	// ==========================================================
	// Bus slave and registers
	mud_pkg::mud_ctrl_t ctrl_r;
	mud_pkg::mud_fmt_t fmt;
	logic wr_pend_r;
	logic [7:0] wr_ofs_r;
	logic addr_ok;
	logic rd_pop;
	logic data_mode_r, carrier_r, ri_on_r;
	logic ok_req_r, frame_err_r, par_err_r, overrun_r;
	logic [31:0] status;
	logic [31:0] rd_val;
	logic hold_v_r;
	logic [7:0] hold_r;
	logic tx_load;

	assign fmt = fmt_dec(ctrl_r.fmt);
	assign addr_ok = hsel_i && hready_i && htrans_i[1];
	assign rd_pop = addr_ok && !hwrite_i && haddr_i[7:0] == `MUD_OFS_RXDATA;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && hwrite_i;
			wr_ofs_r <= haddr_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_r.baud <= `MUD_BAUD_AUTO;
			ctrl_r.fmt <= `MUD_FMT_8N1;
			ctrl_r.par_even <= `MUD_PAR_EVEN;
			ctrl_r.flow <= mud_pkg::FLOW_HW;
			ctrl_r.dsr_cfg <= 1'b1;
			ctrl_r.dcd_cfg <= 1'b1;
			ctrl_r.dtr_cfg <= 1'b1;
			ctrl_r.mux_en <= 1'b0;
			ctrl_r.mux_chan <= 3'h0;
		end else if (wr_pend_r && wr_ofs_r == `MUD_OFS_CTRL) begin
			ctrl_r.baud <= hwdata_i[3:0];
			ctrl_r.fmt <= hwdata_i[6:4];
			ctrl_r.par_even <= hwdata_i[7];
			ctrl_r.flow <= mud_pkg::mud_flow_t'(hwdata_i[9:8]);
			ctrl_r.dsr_cfg <= hwdata_i[10];
			ctrl_r.dcd_cfg <= hwdata_i[11];
			ctrl_r.dtr_cfg <= hwdata_i[12];
			ctrl_r.mux_en <= hwdata_i[13];
			// Channels above five do not exist
			if (hwdata_i[16:14] <= `MUD_MUX_MAX_CHAN)
				ctrl_r.mux_chan <= hwdata_i[16:14];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			hrdata_o <= 32'h0000_0000;
		else if (addr_ok && !hwrite_i)
			hrdata_o <= rd_val;
	end

	// ==========================================================
	// Pin synchronisers, three stages, second and third agree
	logic [2:0] s1_r, s2_r, s3_r, pin_f_r;
	logic txd_f, rts_on, dtr_on;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s1_r <= 3'h7;
			s2_r <= 3'h7;
			s3_r <= 3'h7;
			pin_f_r <= 3'h7;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < 3; i++)
				if (s2_r[i] == s3_r[i])
					pin_f_r[i] <= s3_r[i];
		end
	end
	assign txd_f = pin_f_r[2];
	assign rts_on = !pin_f_r[1];
	assign dtr_on = !pin_f_r[0];

	// ==========================================================
	// One-shot autobaud: width of the start bit of a leading 'A' or 'a'
	mud_pkg::mud_ab_t ab_st_r;
	logic [15:0] ab_cnt_r, ab_div_r, div;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ab_st_r <= mud_pkg::AB_WAIT;
			ab_cnt_r <= 16'h0000;
			ab_div_r <= 16'h0000;
		end else begin
			unique case (ab_st_r)
				mud_pkg::AB_WAIT: begin
					// Abandoned for good once a fixed rate is chosen
					if (ctrl_r.baud != `MUD_BAUD_AUTO)
						ab_st_r <= mud_pkg::AB_DONE;
					else if (!txd_f) begin
						ab_st_r <= mud_pkg::AB_MEAS;
						ab_cnt_r <= 16'h0001;
					end
				end
				mud_pkg::AB_MEAS: begin
					if (txd_f) begin
						ab_st_r <= mud_pkg::AB_DONE;
						ab_div_r <= (ab_cnt_r < `MUD_AB_MIN_DIV) ?
							`MUD_AB_MIN_DIV : ab_cnt_r;
					end else if (ab_cnt_r != 16'hffff)
						ab_cnt_r <= ab_cnt_r + 16'h0001;
				end
				mud_pkg::AB_DONE: ab_st_r <= mud_pkg::AB_DONE;
				default: ab_st_r <= mud_pkg::AB_WAIT;
			endcase
		end
	end
	// Measured rate is kept, and reused if auto is selected again later
	assign div = (ctrl_r.baud == `MUD_BAUD_AUTO && ab_div_r != 16'h0000) ?
		ab_div_r : rate_div(ctrl_r.baud);

	// ==========================================================
	// Receiver and its buffer
	logic rx_en, rx_busy_r, rx_prev_r, rx_done;
	logic [15:0] rx_cnt_r;
	logic [3:0] rx_idx_r, nbits;
	logic [11:0] rx_fr_r;
	logic [7:0] rx_data;
	logic rx_par, rx_stop, rx_is_flow;
	logic [7:0] rxq_r [`MUD_RX_DEPTH];
	logic [2:0] rxq_wp_r, rxq_rp_r;
	logic [3:0] rxq_n_r;
	logic rxq_push, rxq_pop, peer_xoff_r;

	assign nbits = 4'(fmt.db8 ? 10 : 9) + 4'(fmt.pe) + 4'(fmt.stop2);
	assign rx_en = ab_st_r == mud_pkg::AB_DONE;
	assign rx_data = fmt.db8 ? rx_fr_r[8:1] : {1'b0, rx_fr_r[7:1]};
	assign rx_par = fmt.db8 ? rx_fr_r[9] : rx_fr_r[8];
	// Stop bit read live: the frame register is written at this same edge
	assign rx_stop = txd_f;
	assign rx_done = rx_busy_r && rx_cnt_r == 16'h0000 &&
		rx_idx_r == 4'(nbits - 4'h1 - 4'(fmt.stop2));
	assign rx_is_flow = ctrl_r.flow == mud_pkg::FLOW_SW &&
		(rx_data == `MUD_XON || rx_data == `MUD_XOFF);
	assign rxq_push = rx_done && rx_stop && !rx_is_flow &&
		rxq_n_r != 4'(`MUD_RX_DEPTH);
	assign rxq_pop = rd_pop && rxq_n_r != 4'h0;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rx_busy_r <= 1'b0;
			rx_prev_r <= 1'b1;
			rx_cnt_r <= 16'h0000;
			rx_idx_r <= 4'h0;
			rx_fr_r <= 12'hfff;
		end else begin
			rx_prev_r <= txd_f;
			if (!rx_busy_r) begin
				if (rx_en && rx_prev_r && !txd_f) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= {1'b0, div[15:1]};
					rx_idx_r <= 4'h0;
				end
			end else if (rx_cnt_r != 16'h0000)
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			else begin
				rx_fr_r[rx_idx_r] <= txd_f;
				rx_cnt_r <= div - 16'h0001;
				rx_idx_r <= rx_idx_r + 4'h1;
				// A start bit that is gone again was a glitch
				if ((rx_idx_r == 4'h0 && txd_f) || rx_done)
					rx_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rxq_push)
			rxq_r[rxq_wp_r] <= rx_data;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rxq_wp_r <= 3'h0;
			rxq_rp_r <= 3'h0;
			rxq_n_r <= 4'h0;
		end else begin
			if (rxq_push)
				rxq_wp_r <= rxq_wp_r + 3'h1;
			if (rxq_pop)
				rxq_rp_r <= rxq_rp_r + 3'h1;
			rxq_n_r <= rxq_n_r + 4'(rxq_push) - 4'(rxq_pop);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || ctrl_r.flow != mud_pkg::FLOW_SW)
			peer_xoff_r <= 1'b0;
		else if (rx_done && rx_stop && rx_is_flow)
			peer_xoff_r <= rx_data == `MUD_XOFF;
	end

	// ==========================================================
	// Transmitter
	logic tx_busy_r, tx_allow, xo_sent_r, xreq, tx_xload;
	logic [15:0] tx_cnt_r;
	logic [3:0] tx_idx_r;
	logic [11:0] tx_sh_r, tx_fr;
	logic [7:0] tx_char;
	logic cts_off;

	// CTS drops with three free slots left in the buffer
	assign cts_off = rxq_n_r >= `MUD_RX_CTS_TH;
	// Flow is checked only between frames: at most one more leaves
	assign tx_allow = ctrl_r.flow == mud_pkg::FLOW_HW ? rts_on :
		ctrl_r.flow == mud_pkg::FLOW_SW ? !peer_xoff_r : 1'b1;
	assign xreq = ctrl_r.flow == mud_pkg::FLOW_SW && (xo_sent_r != cts_off);
	assign tx_xload = !tx_busy_r && xreq;
	assign tx_load = !tx_busy_r && !xreq && hold_v_r && tx_allow;
	assign tx_char = xreq ? (xo_sent_r ? `MUD_XON : `MUD_XOFF) : hold_r;

	always_comb begin
		tx_fr = 12'hfff;
		tx_fr[0] = 1'b0;
		if (fmt.db8) begin
			tx_fr[8:1] = tx_char;
			if (fmt.pe)
				tx_fr[9] = par_of(tx_char, 1'b1, ctrl_r.par_even);
		end else begin
			tx_fr[7:1] = tx_char[6:0];
			if (fmt.pe)
				tx_fr[8] = par_of(tx_char, 1'b0, ctrl_r.par_even);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || ctrl_r.flow != mud_pkg::FLOW_SW)
			xo_sent_r <= 1'b0;
		else if (tx_xload)
			xo_sent_r <= !xo_sent_r;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= 16'h0000;
			tx_idx_r <= 4'h0;
			tx_sh_r <= 12'hfff;
		end else if (!tx_busy_r) begin
			if (tx_load || tx_xload) begin
				tx_busy_r <= 1'b1;
				tx_sh_r <= tx_fr;
				tx_cnt_r <= div - 16'h0001;
				tx_idx_r <= 4'h0;
			end
		end else if (tx_cnt_r != 16'h0000)
			tx_cnt_r <= tx_cnt_r - 16'h0001;
		else begin
			tx_cnt_r <= div - 16'h0001;
			tx_sh_r <= {1'b1, tx_sh_r[11:1]};
			tx_idx_r <= tx_idx_r + 4'h1;
			if (tx_idx_r == nbits - 4'h1)
				tx_busy_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			hold_v_r <= 1'b0;
			hold_r <= 8'h00;
		end else if (wr_pend_r && wr_ofs_r == `MUD_OFS_TXDATA && !hold_v_r) begin
			hold_v_r <= 1'b1;
			hold_r <= hwdata_i[7:0];
		end else if (tx_load)
			hold_v_r <= 1'b0;
	end

	// ==========================================================
	// Modem status lines and sticky status
	logic dtr_prev_r, dtr_drop, st_clr;
	assign dtr_drop = dtr_prev_r && !dtr_on;
	assign st_clr = wr_pend_r && wr_ofs_r == `MUD_OFS_STATUS;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dtr_prev_r <= 1'b0;
			data_mode_r <= 1'b0;
			carrier_r <= 1'b0;
			ri_on_r <= 1'b0;
		end else begin
			dtr_prev_r <= dtr_on;
			if (wr_pend_r && wr_ofs_r == `MUD_OFS_MODEM) begin
				data_mode_r <= hwdata_i[0];
				carrier_r <= hwdata_i[1];
				ri_on_r <= hwdata_i[2];
			end
			// Drop of DTR overrides a software write in the same cycle
			if (dtr_drop && ctrl_r.dtr_cfg)
				data_mode_r <= 1'b0;
		end
	end

	// Hardware set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ok_req_r <= 1'b0;
			frame_err_r <= 1'b0;
			par_err_r <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			ok_req_r <= (dtr_drop && ctrl_r.dtr_cfg) ||
				(ok_req_r && !(st_clr && hwdata_i[`MUD_ST_OK_REQ]));
			frame_err_r <= (rx_done && !rx_stop) ||
				(frame_err_r && !(st_clr && hwdata_i[`MUD_ST_FRAME_ERR]));
			par_err_r <= (rx_done && fmt.pe &&
				rx_par != par_of(rx_data, fmt.db8, ctrl_r.par_even)) ||
				(par_err_r && !(st_clr && hwdata_i[`MUD_ST_PAR_ERR]));
			overrun_r <= (rx_done && rx_stop && !rx_is_flow &&
				rxq_n_r == 4'(`MUD_RX_DEPTH)) ||
				(overrun_r && !(st_clr && hwdata_i[`MUD_ST_OVERRUN]));
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[`MUD_ST_AB_DONE] = ab_div_r != 16'h0000;
		status[`MUD_ST_TX_BUSY] = tx_busy_r;
		status[`MUD_ST_HOLD_FULL] = hold_v_r;
		status[`MUD_ST_RX_AVAIL] = rxq_n_r != 4'h0;
		status[7:4] = rxq_n_r;
		status[`MUD_ST_DATA_MODE] = data_mode_r;
		status[`MUD_ST_OK_REQ] = ok_req_r;
		status[`MUD_ST_FRAME_ERR] = frame_err_r;
		status[`MUD_ST_PAR_ERR] = par_err_r;
		status[`MUD_ST_CTS_OFF] = cts_off;
		status[`MUD_ST_RTS_ON] = rts_on;
		status[`MUD_ST_DTR_ON] = dtr_on;
		status[`MUD_ST_OVERRUN] = overrun_r;
		unique case (haddr_i[7:0])
			`MUD_OFS_CTRL: rd_val = {15'h0000, ctrl_r};
			`MUD_OFS_STATUS: rd_val = status;
			`MUD_OFS_RXDATA: rd_val = {24'h000000, rxq_r[rxq_rp_r]};
			`MUD_OFS_MODEM: rd_val = {29'h0, ri_on_r, carrier_r, data_mode_r};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Pin drivers: all lines high (OFF) and undriven during reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pin_oe_o <= 1'b0;
			pin_o <= '1;
		end else begin
			pin_oe_o <= 1'b1;
			pin_o.rxd <= tx_busy_r ? tx_sh_r[0] : 1'b1;
			pin_o.cts <= cts_off;
			pin_o.dsr <= ctrl_r.dsr_cfg ? !data_mode_r : 1'b0;
			pin_o.dcd <= ctrl_r.dcd_cfg ? !carrier_r : 1'b0;
			pin_o.ri <= !ri_on_r;
		end
	end
	// Pull-ups on TXD, RTS and DTR stay on at all times
	assign pullup_en_o = 1'b1;
endmodule : mud_uart

/* File: mud_defines.svh */
// Constants of the modem-side serial port: offsets, fields, resets, timing.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef MUD_DEFINES_SVH
`define MUD_DEFINES_SVH
// ==========================================================
// Timing
`define MUD_SYS_CLK_HZ 25000000
`define MUD_RATE_9600 9600
`define MUD_RATE_19200 19200
`define MUD_RATE_38400 38400
`define MUD_RATE_57600 57600
`define MUD_RATE_115200 115200
`define MUD_RATE_230400 230400
`define MUD_RATE_460800 460800
`define MUD_RATE_921600 921600
`define MUD_AB_MIN_DIV 16'h0008
// ==========================================================
// Register byte offsets
`define MUD_OFS_CTRL 8'h00
`define MUD_OFS_STATUS 8'h04
`define MUD_OFS_TXDATA 8'h08
`define MUD_OFS_RXDATA 8'h0c
`define MUD_OFS_MODEM 8'h10
// ==========================================================
// Control reset values and codes
`define MUD_BAUD_AUTO 4'h0
`define MUD_FMT_8N2 3'h1
`define MUD_FMT_8P1 3'h2
`define MUD_FMT_8N1 3'h3
`define MUD_FMT_7N2 3'h4
`define MUD_FMT_7P1 3'h5
`define MUD_FMT_7N1 3'h6
`define MUD_PAR_EVEN 1'b1
`define MUD_MUX_MAX_CHAN 3'h5
// ==========================================================
// Status bit positions
`define MUD_ST_AB_DONE 0
`define MUD_ST_TX_BUSY 1
`define MUD_ST_HOLD_FULL 2
`define MUD_ST_RX_AVAIL 3
`define MUD_ST_DATA_MODE 8
`define MUD_ST_OK_REQ 9
`define MUD_ST_FRAME_ERR 10
`define MUD_ST_PAR_ERR 11
`define MUD_ST_CTS_OFF 12
`define MUD_ST_RTS_ON 13
`define MUD_ST_DTR_ON 14
`define MUD_ST_OVERRUN 15
// ==========================================================
// Flow control characters and receive buffer
`define MUD_XON 8'h11
`define MUD_XOFF 8'h13
`define MUD_RX_DEPTH 8
`define MUD_RX_CTS_TH 4'h5
`endif

/* File: mud_pkg.sv */
// Types of the modem-side serial port.
// Assumes mud_defines.svh holds every number these types meet.
package mud_pkg;
	// ==========================================================
	// Modes and states
	typedef enum logic [1:0] {FLOW_NONE, FLOW_SW, FLOW_HW, FLOW_RSVD} mud_flow_t;
	typedef enum logic [1:0] {AB_WAIT, AB_MEAS, AB_DONE} mud_ab_t;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [2:0] mux_chan;
		logic mux_en;
		logic dtr_cfg;
		logic dcd_cfg;
		logic dsr_cfg;
		mud_flow_t flow;
		logic par_even;
		logic [2:0] fmt;
		logic [3:0] baud;
	} mud_ctrl_t;
	typedef struct packed {
		logic db8;
		logic pe;
		logic stop2;
	} mud_fmt_t;
	typedef struct packed {
		logic txd;
		logic rts;
		logic dtr;
	} mud_pin_in_t;
	typedef struct packed {
		logic rxd;
		logic cts;
		logic dsr;
		logic dcd;
		logic ri;
	} mud_pin_out_t;
endpackage : mud_pkg

/* File: mud_uart_chk.sv */
// Port checker of the modem-side serial port, bound to mud_uart.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module mud_uart_chk (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire mud_pkg::mud_pin_in_t pin_i,
	input wire mud_pkg::mud_pin_out_t pin_o,
	input wire logic pin_oe_o,
	input wire logic pullup_en_o
);
	// ==========
	// Properties
	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready or not okay");
	oe_release_a: assert property ($rose(rst_n_i) |-> !pin_oe_o ##1 pin_oe_o)
		else $error("pin drive not enabled one edge after reset");
	oe_hold_a: assert property (pin_oe_o |=> pin_oe_o)
		else $error("pin drive dropped while running");
	cts_init_a: assert property ($rose(rst_n_i) |=> !pin_o.cts && pin_o.rxd)
		else $error("clear-to-send or data line wrong after reset");
	lines_off_a: assert property ($rose(rst_n_i) |=>
		pin_o.dsr && pin_o.dcd && pin_o.ri)
		else $error("status lines not off after reset");
	pullup_on_a: assert property (pullup_en_o)
		else $error("input pull-up disabled");
	start_bit_a: assert property ($fell(pin_o.rxd) |-> !pin_o.rxd [*8])
		else $error("start bit shorter than minimum divisor");
	dtr_drop_a: assert property ($rose(pin_i.dtr) |-> ##[1:8] pin_o.dsr)
		else $error("data-set-ready still on after terminal-ready drop");
endmodule : mud_uart_chk
bind mud_uart mud_uart_chk i_chk (
	.sys_clk_i,
	.rst_n_i,
	.hreadyout_o,
	.hresp_o,
	.pin_i,
	.pin_o,
	.pin_oe_o,
	.pullup_en_o
);

/* File: mud_host.sv */
// Behavioural terminal (DTE) facing the modem-side serial port.
// Assumes the bench sets bit count and divisor only between frames.
`timescale 1ns/10ps
module mud_host (
	input wire logic sys_clk_i,
	input wire logic rxd_i,
	input wire logic [3:0] nbits_i,
	input wire logic [15:0] div_i,
	output logic txd_o,
	output logic [11:0] frame_o,
	output logic frame_vld_o
);
	// ==========
	// Sender, 8N1 only
	initial begin
		txd_o = 1'b1;
		frame_o = 12'hfff;
		frame_vld_o = 1'b0;
	end
	task automatic send(input logic [7:0] c, input int dv);
		logic [9:0] fr;
		fr = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			txd_o <= fr[i];
			repeat (dv) @(posedge sys_clk_i);
		end
	endtask : send
	// ==========
	// Receiver, never stalls, so late frames are still taken
	always begin
		@(negedge rxd_i);
		frame_o <= 12'hfff;
		repeat (div_i / 2) @(posedge sys_clk_i);
		for (int i = 0; i <= int'(nbits_i); i++) begin
			frame_o[i] <= rxd_i;
			if (i < int'(nbits_i)) repeat (div_i) @(posedge sys_clk_i);
		end
		frame_vld_o <= 1'b1;
		@(posedge sys_clk_i);
		frame_vld_o <= 1'b0;
	end
endmodule : mud_host

/* File: tb_top.sv */
// Self-checking bench of the modem-side serial port.
// Assumes mud_host as terminal and the bound port checker.
`timescale 1ns/10ps
`include "mud_defines.svh"
module tb_top;
	logic clk, rst_n, hsel, hwrite, hrdy, hresp, rts, dtr, txd, vld, oe, pu;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, e;
	logic [15:0] div, lfsr;
	logic [11:0] frame;
	logic [11:0] exq[$];
	logic [3:0] nbits;
	logic [2:0] f;
	mud_pkg::mud_pin_out_t po;
	int num_errors, n_tests;
	int dv[9] = '{2604, 1302, 651, 434, 217, 108, 54, 27, 217};
	mud_uart i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.pin_i({txd, rts, dtr}), .pin_o(po), .pin_oe_o(oe),
		.pullup_en_o(pu));
	mud_host i_host (.sys_clk_i(clk), .rxd_i(po.rxd), .nbits_i(nbits),
		.div_i(div), .txd_o(txd), .frame_o(frame), .frame_vld_o(vld));
	// ==========
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, x);
			num_errors++;
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		ahb(1'b0, a, 32'h0);
		chk(rd & m, x);
	endtask : rdc
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	function automatic logic [11:0] frm(input logic [7:0] c,
		input logic [2:0] fm, input logic ev);
		logic [11:0] r;
		logic p;
		int n;
		r = 12'hffe;
		p = 1'b0;
		n = (fm < 3'h4) ? 8 : 7;
		for (int i = 0; i < n; i++) begin
			r[i + 1] = c[i];
			p ^= c[i];
		end
		if (fm == 3'h2 || fm == 3'h5) r[n + 1] = ev ? p : ~p;
		return r;
	endfunction : frm
	task automatic cfg(input logic [3:0] b, input logic [2:0] fm,
		input logic ev, input logic [1:0] fl, input int d);
		ahb(1'b1, `MUD_OFS_CTRL, {19'h0, 3'h7, fl, ev, fm, b});
		nbits <= (fm < 3'h4 ? 4'h8 : 4'h7) + (fm % 3 != 0 ? 4'h2 : 4'h1);
		div <= 16'(d);
	endtask : cfg
	task automatic txc(input logic [7:0] c, input logic [2:0] fm, input logic ev);
		exq.push_back(frm(c, fm, ev));
		ahb(1'b1, `MUD_OFS_TXDATA, {24'h0, c});
	endtask : txc
	task automatic waitq;
		while (exq.size() != 0) @(posedge clk);
		cyc(int'(div));
	endtask : waitq
	task automatic results;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	// ==========
	// Clock, watchdog, frame monitor
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		cyc(95000);
		num_errors++;
		results();
	end
	always @(posedge clk) begin
		if (vld === 1'b1) begin
			e = (exq.size() != 0) ? {20'h0, exq.pop_front()} : 32'hffffffff;
			chk({20'h0, frame}, e);
		end
	end
	// ==========
	// Tests
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		rts = 1'b1;
		dtr = 1'b1;
		nbits = 4'h9;
		div = 16'd217;
		lfsr = 16'hcb94;
		cyc(20);
		rst_n <= 1'b1;
		cyc(2);
		rdc(`MUD_OFS_CTRL, 32'hffffffff, 32'h1eb0);
		chk({28'h0, oe, po.cts, po.rxd, pu}, 32'hb);
		chk({30'h0, po.dsr, po.dcd}, 32'h3);
		rdc(`MUD_OFS_STATUS, 32'h1, 32'h0);
		rdc(8'h14, 32'hffffffff, 32'h0);
		$display("test reset done");
		i_host.send(8'hff, 217);
		cyc(20);
		rdc(`MUD_OFS_STATUS, 32'h1, 32'h1);
		i_host.send(8'h5a, 217);
		cyc(20);
		rdc(`MUD_OFS_RXDATA, 32'hff, 32'h5a);
		$display("test autobaud done");
		rts <= 1'b0;
		for (int b = 1; b < 10; b++) begin
			f = 3'((b - 1) % 6 + 1);
			cfg(4'(b), f, 1'(b), 2'h2, dv[b - 1]);
			repeat ((b > 4) ? 2 : 1) begin
				lfsr = nx(lfsr);
				txc(lfsr[7:0], f, 1'(b));
			end
			waitq();
		end
		$display("test rates done");
		cfg(4'h8, 3'h3, 1'b1, 2'h2, 27);
		rts <= 1'b1;
		cyc(5);
		txc(8'h3c, 3'h3, 1'b1);
		cyc(800);
		chk(32'(exq.size()), 32'h1);
		rts <= 1'b0;
		waitq();
		cfg(4'h8, 3'h3, 1'b1, 2'h0, 27);
		rts <= 1'b1;
		cyc(5);
		txc(8'hc3, 3'h3, 1'b1);
		cyc(800);
		chk(32'(exq.size()), 32'h0);
		cfg(4'h8, 3'h3, 1'b1, 2'h1, 27);
		rts <= 1'b0;
		i_host.send(`MUD_XOFF, 27);
		txc(8'h96, 3'h3, 1'b1);
		cyc(800);
		chk(32'(exq.size()), 32'h1);
		i_host.send(`MUD_XON, 27);
		waitq();
		$display("test flow done");
		cfg(4'h8, 3'h3, 1'b1, 2'h2, 27);
		for (int i = 0; i < 8; i++) begin
			i_host.send(8'(8'h30 + i), 27);
			cyc(5);
			chk(32'(po.cts), 32'(i > 3));
		end
		rdc(`MUD_OFS_STATUS, 32'h80f0, 32'h0080);
		for (int i = 0; i < 8; i++) begin
			rdc(`MUD_OFS_RXDATA, 32'hff, 32'(8'h30 + i));
		end
		cyc(2);
		chk(32'(po.cts), 32'h0);
		$display("test cts done");
		// Host sends 8N1 into 8P1: parity bit sees the host's stop bit
		cfg(4'h8, 3'h2, 1'b1, 2'h2, 27);
		i_host.send(8'h03, 27);
		cyc(40);
		rdc(`MUD_OFS_STATUS, 32'h0c00, 32'h0800);
		// Host sends 8N1 into 7N1: data bit 7 low lands on the stop bit
		cfg(4'h8, 3'h6, 1'b1, 2'h2, 27);
		i_host.send(8'h41, 27);
		cyc(40);
		rdc(`MUD_OFS_STATUS, 32'h0400, 32'h0400);
		$display("test errors done");
		ahb(1'b1, `MUD_OFS_MODEM, 32'h3);
		cyc(3);
		chk({30'h0, po.dsr, po.dcd}, 32'h0);
		dtr <= 1'b0;
		cyc(10);
		rdc(`MUD_OFS_STATUS, 32'h6000, 32'h6000);
		dtr <= 1'b1;
		cyc(10);
		chk({30'h0, po.dsr, po.dcd}, 32'h2);
		rdc(`MUD_OFS_STATUS, 32'h300, 32'h200);
		ahb(1'b1, `MUD_OFS_MODEM, 32'h0);
		cyc(3);
		chk(32'(po.dcd), 32'h1);
		$display("test modem done");
		ahb(1'b1, `MUD_OFS_CTRL, 32'h1beb0);
		rdc(`MUD_OFS_CTRL, 32'h1e000, 32'h2000);
		ahb(1'b1, `MUD_OFS_CTRL, 32'h17eb0);
		rdc(`MUD_OFS_CTRL, 32'h1e000, 32'h16000);
		$display("test mux done");
		chk(32'(exq.size()), 32'h0);
		results();
	end
endmodule : tb_top
